// file: shared/sba_pkg.sv
// shared constants and types for the system bus arbiter
package sba_pkg;
  // priority select settings
  typedef enum logic [1:0]
  {
    SBA_PRI_CPU = 2'h0,
    SBA_PRI_DMA = 2'h1,
    SBA_PRI_DMA_STRONG = 2'h2
  } sba_pri_t;
  // default bridge request codes
  localparam logic [1:0] SBA_REQ_IDLE = 2'h0;
  localparam logic [1:0] SBA_REQ_DMA = 2'h1;
  localparam logic [1:0] SBA_REQ_ATOMIC = 2'h2;
  localparam logic [1:0] SBA_REQ_PREEMPT = 2'h3;
  // processor cycle command idle code
  localparam logic [2:0] SBA_CPU_CMD_IDLE = 3'h0;
  // bridge cycle command idle code
  localparam logic [2:0] SBA_IO_CMD_IDLE = 3'h0;
  // acknowledge codes
  localparam logic [1:0] SBA_IO_ACK_NONE = 2'h0;
  localparam logic [1:0] SBA_IO_ACK_OK = 2'h1;
  localparam logic [2:0] SBA_CPU_ACK_NONE = 3'h0;
endpackage

// file: shared/sba_if.sv
// interface between the arbiter and the bridge
`timescale 1ns/1ps
`default_nettype none
interface sba_if;
  logic [1:0] bridge_bus_request;
  logic [2:0] bridge_cycle_cmd;
  logic bridge_bus_grant;
  logic [1:0] bridge_cycle_ack;
  logic cache_hold_ack;
  modport arbiter
  (
    input bridge_bus_request,
    input bridge_cycle_cmd,
    output bridge_bus_grant,
    output bridge_cycle_ack
  );
  modport bridge
  (
    output bridge_bus_request,
    output bridge_cycle_cmd,
    output cache_hold_ack,
    input bridge_bus_grant,
    input bridge_cycle_ack
  );
endinterface
`default_nettype wire

// file: verilog/sba_arbiter.sv
// arbiter end: decides owner of the shared system bus and cache
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter #(
  parameter logic [1:0] REQ_IDLE = sba_pkg::SBA_REQ_IDLE,
  parameter logic [1:0] REQ_DMA = sba_pkg::SBA_REQ_DMA,
  parameter logic [1:0] REQ_ATOMIC = sba_pkg::SBA_REQ_ATOMIC,
  parameter logic [1:0] REQ_PREEMPT = sba_pkg::SBA_REQ_PREEMPT
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // bridge side
  sba_if.arbiter bus,
  // processor side
  input wire logic [2:0] i_cpu_cycle_cmd,
  input wire logic i_cpu_done,
  input wire logic i_cpu_hold_ack,
  output logic o_cache_hold_request,
  output logic o_cpu_suspend,
  // control and status
  input wire sba_pkg::sba_pri_t i_dma_priority_select,
  input wire logic i_dma_release_ok,
  input wire logic i_dma_done,
  output logic o_cpu_owner,
  output logic o_bridge_granted
);

  // ==========================================================
  // state
  typedef enum logic [1:0]
  {
    SBA_ST_CPU = 2'h0,
    SBA_ST_DMA = 2'h1,
    SBA_ST_REL = 2'h2,
    SBA_ST_WAIT = 2'h3
  } sba_state_t;

  sba_state_t state_q;
  sba_state_t state_d;
  logic hold_ack_meta_q;
  logic hold_ack_q;
  logic [1:0] req_q;
  logic [1:0] req_prev_q;
  logic cpu_busy_q;
  logic grant_q;
  logic hold_q;
  logic suspend_q;
  logic [1:0] ack_q;
  logic owner_q;
  logic hold_d;
  logic cpu_start;
  logic req_any;
  logic req_sticky;
  logic dma_wins;

  // ==========================================================
  // input synchronisers for the hold ack and bridge request pins
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      hold_ack_meta_q <= 1'b0;
      hold_ack_q <= 1'b0;
    end
    else
    begin
      hold_ack_meta_q <= i_cpu_hold_ack;
      hold_ack_q <= hold_ack_meta_q;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      req_q <= REQ_IDLE;
      req_prev_q <= REQ_IDLE;
    end
    else
    begin
      req_q <= bus.bridge_bus_request;
      req_prev_q <= req_q;
    end
  end

  // ==========================================================
  // request decode
  always_comb
  begin
    req_any = (req_q != REQ_IDLE);
    // command is a started transaction; ignored under hold
    cpu_start = (i_cpu_cycle_cmd != sba_pkg::SBA_CPU_CMD_IDLE) && !hold_q && !hold_ack_q;
    // strong keeps bus; atomic or preempt never release
    req_sticky = (req_q == REQ_ATOMIC) || (req_q == REQ_PREEMPT) ||
      ((i_dma_priority_select == sba_pkg::SBA_PRI_DMA_STRONG) && req_any);
    // processor priority; plain request no extra precedence
    // processor already started wins unless preempt has suspended it; atomic as plain here
    dma_wins = req_any && ((!cpu_busy_q && !cpu_start) || suspend_q);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      cpu_busy_q <= 1'b0;
    end
    else if (cpu_start)
    begin
      cpu_busy_q <= 1'b1;
    end
    else if (i_cpu_done)
    begin
      cpu_busy_q <= 1'b0;
    end
  end

  // ==========================================================
  // ownership state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SBA_ST_CPU:
      begin
        // processor default; dma win takes cache
        if (dma_wins)
        begin
          state_d = SBA_ST_DMA;
        end
      end
      SBA_ST_DMA:
      begin
        if (i_dma_done)
        begin
          state_d = SBA_ST_WAIT;
        end
        else if (i_dma_release_ok && !req_sticky)
        begin
          state_d = SBA_ST_REL;
        end
      end
      SBA_ST_REL:
      begin
        if (i_dma_done)
        begin
          state_d = SBA_ST_WAIT;
        end
      end
      SBA_ST_WAIT:
      begin
        // atomic in progress keeps serving bridge
        if ((req_q == REQ_ATOMIC) && hold_q)
        begin
          state_d = SBA_ST_DMA;
        end
        // wait for hold ack to drop
        else if (!hold_ack_q)
        begin
          state_d = SBA_ST_CPU;
        end
      end
      default:
      begin
        state_d = SBA_ST_CPU;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= SBA_ST_CPU;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // outputs
  always_comb
  begin
    hold_d = (state_d == SBA_ST_DMA) || (state_d == SBA_ST_REL) ||
      ((state_d == SBA_ST_WAIT) && (state_q != SBA_ST_WAIT));
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      grant_q <= 1'b0;
      hold_q <= 1'b0;
      owner_q <= 1'b1;
      ack_q <= sba_pkg::SBA_IO_ACK_NONE;
    end
    else
    begin
      grant_q <= (state_d == SBA_ST_DMA);
      hold_q <= hold_d;
      owner_q <= !hold_d;
      ack_q <= ((state_q != SBA_ST_CPU) && (state_q != SBA_ST_WAIT) && i_dma_done) ?
        sba_pkg::SBA_IO_ACK_OK : sba_pkg::SBA_IO_ACK_NONE;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      suspend_q <= 1'b0;
    end
    else if ((req_q == REQ_PREEMPT) && cpu_busy_q)
    begin
      suspend_q <= 1'b1;
    end
    else if ((req_prev_q == REQ_PREEMPT) && (req_q != REQ_PREEMPT))
    begin
      suspend_q <= 1'b0;
    end
  end

  assign bus.bridge_bus_grant = grant_q;
  assign bus.bridge_cycle_ack = ack_q;
  assign o_cache_hold_request = hold_q;
  assign o_cpu_suspend = suspend_q;
  assign o_cpu_owner = owner_q;
  assign o_bridge_granted = grant_q;

endmodule
`default_nettype wire

// file: verilog/sba_bridge.sv
// bridge end: raises requests and drives commands once owner
`timescale 1ns/1ps
`default_nettype none
module sba_bridge #(
  parameter logic [1:0] REQ_IDLE = sba_pkg::SBA_REQ_IDLE
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // arbiter side
  sba_if.bridge bus,
  // user side
  input wire logic [1:0] i_req_code,
  input wire logic [2:0] i_cmd,
  input wire logic i_cpu_hold_ack,
  output logic o_cmd_issued,
  output logic o_done
);

  // ==========================================================
  // registers
  logic [1:0] req_q;
  logic [2:0] cmd_q;
  logic issued_q;
  logic done_q;
  logic hold_meta_q;
  logic hold_q;
  logic ack_seen;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      hold_meta_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      hold_meta_q <= i_cpu_hold_ack;
      hold_q <= hold_meta_q;
    end
  end

  // grant and ack come from same-clock logic
  assign ack_seen = (bus.bridge_cycle_ack != sba_pkg::SBA_IO_ACK_NONE);

  // ==========================================================
  // request and command
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      req_q <= REQ_IDLE;
      cmd_q <= sba_pkg::SBA_IO_CMD_IDLE;
      issued_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      // atomic code presented with first command
      // user holds preempt/atomic code; user picks preempt
      req_q <= i_req_code;
      done_q <= ack_seen;
      // drive only with grant and hold ack
      if (bus.bridge_bus_grant && hold_q && !issued_q)
      begin
        cmd_q <= i_cmd;
        issued_q <= 1'b1;
      end
      else
      begin
        cmd_q <= sba_pkg::SBA_IO_CMD_IDLE;
        if (ack_seen)
        begin
          issued_q <= 1'b0;
        end
      end
    end
  end

  assign bus.bridge_bus_request = req_q;
  assign bus.bridge_cycle_cmd = cmd_q;
  assign bus.cache_hold_ack = hold_q;
  assign o_cmd_issued = issued_q;
  assign o_done = done_q;

endmodule
`default_nettype wire

// file: verification/sba_asserts.sv
// concurrent checks on the arbiter to bridge interface
`timescale 1ns/1ps
`default_nettype none
module sba_asserts
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // interface signals
  input wire logic [1:0] bridge_bus_request,
  input wire logic [2:0] bridge_cycle_cmd,
  input wire logic bridge_bus_grant,
  input wire logic [1:0] bridge_cycle_ack,
  input wire logic cache_hold_ack
);
  // ==========
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_grant_needs_req: assert property (
    $rose(bridge_bus_grant) |-> $past(bridge_bus_request, 2) != sba_pkg::SBA_REQ_IDLE)
    else $error("grant without request");
  a_grant_hold_clear: assert property (
    $rose(bridge_bus_grant) |-> !cache_hold_ack)
    else $error("grant before hold ack dropped");
  a_grant_latency: assert property (
    $rose(bridge_bus_request == sba_pkg::SBA_REQ_DMA) |-> ##[2:60] bridge_bus_grant)
    else $error("request not granted in time");
  a_grant_cmd_idle: assert property (
    $rose(bridge_bus_grant) |-> bridge_cycle_cmd == sba_pkg::SBA_IO_CMD_IDLE)
    else $error("command before grant");
  a_ack_pulse: assert property (
    bridge_cycle_ack != sba_pkg::SBA_IO_ACK_NONE |=> bridge_cycle_ack == sba_pkg::SBA_IO_ACK_NONE)
    else $error("ack longer than one cycle");
  a_ack_code: assert property (
    bridge_cycle_ack != sba_pkg::SBA_IO_ACK_NONE |-> bridge_cycle_ack == sba_pkg::SBA_IO_ACK_OK)
    else $error("bad ack code");
  a_cmd_needs_owner: assert property (
    bridge_cycle_cmd != sba_pkg::SBA_IO_CMD_IDLE |->
      $past(bridge_bus_grant) && $past(cache_hold_ack))
    else $error("command without grant and hold ack");
  a_cmd_one_cycle: assert property (
    bridge_cycle_cmd != sba_pkg::SBA_IO_CMD_IDLE |=> bridge_cycle_cmd == sba_pkg::SBA_IO_CMD_IDLE)
    else $error("command held too long");
endmodule
`default_nettype wire

// file: verification/tb_system_bus_arbiter.sv
// testbench joining arbiter and bridge ends
`timescale 1ns/1ps
`default_nettype none
module tb_system_bus_arbiter;
  // ==========
  // stimulus and wiring
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] cpu_cmd = 3'h0;
  logic cpu_done = 1'b0;
  logic hold_ack = 1'b0;
  logic rel_ok = 1'b0;
  logic dma_done = 1'b0;
  logic [1:0] req = 2'h0;
  sba_pkg::sba_pri_t pri = sba_pkg::SBA_PRI_CPU;
  logic hold_req, suspend, owner, granted, issued, done;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  logic done_seen = 1'b0;
  sba_if bus();
  always #2 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) hold_ack <= hold_req;
  always @(posedge i_sys_clk) if (done) done_seen <= 1'b1;
  sba_arbiter i_sba_arbiter(.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .bus(bus.arbiter),
    .i_cpu_cycle_cmd(cpu_cmd), .i_cpu_done(cpu_done), .i_cpu_hold_ack(hold_ack),
    .o_cache_hold_request(hold_req), .o_cpu_suspend(suspend), .i_dma_priority_select(pri),
    .i_dma_release_ok(rel_ok), .i_dma_done(dma_done), .o_cpu_owner(owner),
    .o_bridge_granted(granted));
  sba_bridge i_sba_bridge(.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .bus(bus.bridge),
    .i_req_code(req), .i_cmd(3'h5), .i_cpu_hold_ack(hold_ack), .o_cmd_issued(issued),
    .o_done(done));
  sba_asserts i_sba_asserts(.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .bridge_bus_request(bus.bridge_bus_request), .bridge_cycle_cmd(bus.bridge_cycle_cmd),
    .bridge_bus_grant(bus.bridge_bus_grant), .bridge_cycle_ack(bus.bridge_cycle_ack),
    .cache_hold_ack(bus.cache_hold_ack));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 60)
    begin
      @(negedge i_sys_clk);
      k++;
    end
    if (s !== v)
    begin
      error_cnt++;
      $display("BAD wait expected %0h seen %0h", v, s);
    end
  endtask
  task automatic start_dma(input logic [1:0] code);
    req = code;
    wait_for(granted, 1'b1);
    chk("grant", 3'h1, granted);
    chk("hold", 3'h1, hold_req);
  endtask
  task automatic end_dma();
    req = 2'h0;
    rel_ok = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    dma_done = 1'b1;
    @(negedge i_sys_clk);
    dma_done = 1'b0;
    wait_for(hold_req, 1'b0);
    repeat (3) @(negedge i_sys_clk);
    chk("owner", 3'h1, owner);
  endtask
  task automatic cpu_pulse(ref logic [2:0] c);
    c = 3'h1;
    @(negedge i_sys_clk);
    c = 3'h0;
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  // ==========
  // tests
  initial
  begin
    repeat (3) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    chk("grant", 3'h0, granted);
    chk("owner", 3'h1, owner);
    $display("test reset done");
    for (int p = 0; p < 3; p++)
    begin
      pri = sba_pkg::sba_pri_t'(p);
      start_dma(sba_pkg::SBA_REQ_DMA);
      cpu_pulse(cpu_cmd);
      wait_for(issued, 1'b1);
      chk("issued", 3'h1, issued);
      end_dma();
    end
    chk("done", 3'h1, done_seen);
    $display("test priorities done");
    pri = sba_pkg::SBA_PRI_DMA;
    req = sba_pkg::SBA_REQ_DMA;
    cpu_pulse(cpu_cmd);
    repeat (4) @(negedge i_sys_clk);
    chk("grant", 3'h0, granted);
    cpu_done = 1'b1;
    @(negedge i_sys_clk);
    cpu_done = 1'b0;
    start_dma(sba_pkg::SBA_REQ_DMA);
    end_dma();
    $display("test cpu first done");
    cpu_pulse(cpu_cmd);
    req = sba_pkg::SBA_REQ_PREEMPT;
    wait_for(suspend, 1'b1);
    chk("suspend", 3'h1, suspend);
    wait_for(granted, 1'b1);
    chk("grant", 3'h1, granted);
    req = sba_pkg::SBA_REQ_DMA;
    wait_for(suspend, 1'b0);
    chk("suspend", 3'h0, suspend);
    end_dma();
    cpu_done = 1'b1;
    @(negedge i_sys_clk);
    cpu_done = 1'b0;
    start_dma(sba_pkg::SBA_REQ_ATOMIC);
    end_dma();
    $display("test preempt done");
    for (int t = 0; t < 3; t++)
    begin
      pri = (t == 1) ? sba_pkg::SBA_PRI_DMA_STRONG : sba_pkg::SBA_PRI_DMA;
      start_dma((t == 2) ? sba_pkg::SBA_REQ_ATOMIC : sba_pkg::SBA_REQ_DMA);
      rel_ok = 1'b1;
      n = 0;
      repeat (4)
      begin
        @(negedge i_sys_clk);
        n += !granted;
      end
      chk("released", 3'((t == 0)), 3'((n != 0)));
      end_dma();
    end
    $display("test release done");
    wrap_up();
  end
endmodule
`default_nettype wire
